// ===== logic/asrt_pkg.sv
/*
  Constants for the arbiter status and reserve-time block: register
  offsets, status bit positions, reset values and timing counts.
  Assumes a 40 MHz device clock.
*/
`default_nettype none
package asrt_pkg;
  // Register offsets
  localparam logic [7:0] ARBITER_STATUS_OFS = 8'h02;
  localparam logic [7:0] RESERVATION_PERIOD_OFS = 8'h03;
  // Reset values
  localparam logic [7:0] ARBITER_STATUS_RST = 8'h00;
  localparam logic [7:0] RESERVATION_PERIOD_RST = 8'h00;
  // Status bit positions
  localparam int SELF_ALERT_TRIGGER_BIT = 5;
  localparam int INBOX_HAS_MAIL_BIT = 4;
  localparam int OUTBOX_WAS_READ_BIT = 3;
  localparam int DOWNSTREAM_STUCK_BIT = 2;
  localparam int RECOVERY_FAILED_BIT = 1;
  localparam int PEER_OWNS_BUS_BIT = 0;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_IN_NS = 1_000_000;
  localparam int HUNG_TIME_MS = 500;
  localparam int TICK_CYCLES = MS_IN_NS / CLK_PERIOD_NS;
  localparam int HUNG_CYCLES = HUNG_TIME_MS * TICK_CYCLES;
  localparam int HUNG_CNT_W = 25;
  localparam int TICK_CNT_W = 16;
endpackage
`default_nettype wire

// ===== logic/asrt_arbiter.sv
/*
  Status register view, self-test alert, mailbox flags, downstream
  stuck detection and reservation timer of a two-master bus arbiter.
  Assumes an upstream slave front end on clk that presents register
  writes as one-cycle strobes, and neighbouring blocks for the mailbox
  data, control register and interrupt status/mask.
*/
`timescale 1ns/1ps
`default_nettype none
module asrt_arbiter #(
  parameter int unsigned TICK_CYC = asrt_pkg::TICK_CYCLES,
  parameter int unsigned HUNG_CYC = asrt_pkg::HUNG_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register access, one lane per upstream master
  input wire logic [1:0] reg_wr,
  input wire logic [1:0][7:0] reg_addr,
  input wire logic [1:0][7:0] reg_wdata,
  output logic [1:0][7:0] reg_rdata,
  // Neighbouring blocks
  input wire logic [1:0] mail_written,
  input wire logic [1:0] mail_taken,
  input wire logic [1:0] self_alert_flag_clr,
  input wire logic [1:0] self_alert_mask,
  input wire logic [1:0] ownership_request,
  input wire logic init_failed,
  output logic [1:0] ownership_granted,
  output logic [1:0] self_alert_active,
  // Pins
  input wire logic ds_sda_in,
  input wire logic ds_scl_in,
  output logic [1:0] upstream_alert_n
);
  logic sda_s1_r, sda_s2_r, scl_s1_r, scl_s2_r, scl_d_r;
  logic [1:0] alert_r, alert_nxt, alert_n_r, alert_n_nxt;
  logic [1:0] full_r, full_nxt, grant_r, grant_nxt;
  logic [1:0][7:0] rt_r, rt_nxt, rdata_r, rdata_nxt;
  logic last_r, last_nxt, timed_r, timed_nxt, stuck_r, stuck_nxt, fail_r, fail_nxt;
  logic [7:0] remain_r, remain_nxt;
  logic [asrt_pkg::TICK_CNT_W-1:0] pre_r, pre_nxt;
  logic [asrt_pkg::HUNG_CNT_W-1:0] hung_r, hung_nxt;
  logic owner;

  function automatic logic [7:0] status_view(input logic m);
    logic [7:0] v;
    v = 8'h00;
    v[asrt_pkg::INBOX_HAS_MAIL_BIT] = full_r[m];
    v[asrt_pkg::OUTBOX_WAS_READ_BIT] = ~full_r[~m];
    v[asrt_pkg::DOWNSTREAM_STUCK_BIT] = stuck_r;
    v[asrt_pkg::RECOVERY_FAILED_BIT] = fail_r;
    v[asrt_pkg::PEER_OWNS_BUS_BIT] = grant_r[~m];
    return v;
  endfunction

  function automatic logic is_write(input logic m, input logic [7:0] ofs);
    return reg_wr[m] && (reg_addr[m] == ofs);
  endfunction

  // Pins cross into clk through two flops
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
    end
    else
    begin
      sda_s1_r <= ds_sda_in;
      sda_s2_r <= sda_s1_r;
      scl_s1_r <= ds_scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
    end
  end

  always_comb
  begin
    alert_nxt = alert_r;
    full_nxt = full_r;
    rt_nxt = rt_r;
    grant_nxt = grant_r;
    last_nxt = last_r;
    timed_nxt = timed_r;
    remain_nxt = remain_r;
    pre_nxt = pre_r;
    owner = grant_r[1];
    for (int m = 0; m < 2; m++)
    begin
      // per-master trigger; zero ignored; set beats clear
      alert_nxt[m] = (is_write(1'(m), asrt_pkg::ARBITER_STATUS_OFS)
                      && reg_wdata[m][asrt_pkg::SELF_ALERT_TRIGGER_BIT])
                     || (alert_r[m] && !self_alert_flag_clr[m]);
      // inbox filled by peer, emptied by own read
      full_nxt[m] = mail_written[1 - m] || (full_r[m] && !mail_taken[m]);
      // stored length only sampled at grant
      if (is_write(1'(m), asrt_pkg::RESERVATION_PERIOD_OFS))
        rt_nxt[m] = reg_wdata[m];
    end
    if (pre_r == asrt_pkg::TICK_CNT_W'(TICK_CYC - 1))
    begin
      pre_nxt = '0;
      if (timed_r && remain_r != 8'h00)
        remain_nxt = remain_r - 8'h01;
    end
    else
      pre_nxt = pre_r + 1'b1;
    if (grant_r == 2'b00)
    begin
      if (ownership_request != 2'b00)
      begin
        // Alternate on a tie so neither master starves
        if (ownership_request == 2'b11)
          owner = ~last_r;
        else
          owner = ownership_request[1];
        grant_nxt = 2'b01 << owner;
      end
    end
    else if (!ownership_request[owner])
      grant_nxt = 2'b00;
    // hand over only after a timed period expires
    else if (ownership_request[~owner] && timed_r && remain_r == 8'h00)
    begin
      owner = ~owner;
      grant_nxt = 2'b01 << owner;
    end
    // new grant loads and restarts the timer
    if (grant_nxt != 2'b00 && grant_nxt != grant_r)
    begin
      last_nxt = owner;
      remain_nxt = rt_r[owner];
      timed_nxt = rt_r[owner] != 8'h00;
      pre_nxt = '0;
    end
    // either line low counts; a clock edge or idle bus restarts
    if ((scl_s2_r != scl_d_r) || (sda_s2_r && scl_s2_r))
      hung_nxt = '0;
    else if (hung_r != asrt_pkg::HUNG_CNT_W'(HUNG_CYC))
      hung_nxt = hung_r + 1'b1;
    else
      hung_nxt = hung_r;
    stuck_nxt = hung_nxt == asrt_pkg::HUNG_CNT_W'(HUNG_CYC);
    // failure level from the initialization sequencer
    fail_nxt = init_failed;
    // alert line low while alert unmasked
    alert_n_nxt = ~(alert_r & ~self_alert_mask);
    // per-port view; trigger bit reads zero
    for (int m = 0; m < 2; m++)
    begin
      if (reg_addr[m] == asrt_pkg::ARBITER_STATUS_OFS)
        rdata_nxt[m] = status_view(1'(m));
      else if (reg_addr[m] == asrt_pkg::RESERVATION_PERIOD_OFS)
        rdata_nxt[m] = rt_r[m];
      else
        rdata_nxt[m] = 8'h00;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      alert_r <= 2'b00;
      alert_n_r <= 2'b11;
      full_r <= 2'b00;
      rt_r <= {2{asrt_pkg::RESERVATION_PERIOD_RST}};
      grant_r <= 2'b00;
      last_r <= 1'b1;
      timed_r <= 1'b0;
      remain_r <= 8'h00;
      pre_r <= '0;
      hung_r <= '0;
      stuck_r <= 1'b0;
      fail_r <= 1'b0;
      rdata_r <= {2{asrt_pkg::ARBITER_STATUS_RST}};
    end
    else
    begin
      alert_r <= alert_nxt;
      alert_n_r <= alert_n_nxt;
      full_r <= full_nxt;
      rt_r <= rt_nxt;
      grant_r <= grant_nxt;
      last_r <= last_nxt;
      timed_r <= timed_nxt;
      remain_r <= remain_nxt;
      pre_r <= pre_nxt;
      hung_r <= hung_nxt;
      stuck_r <= stuck_nxt;
      fail_r <= fail_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign ownership_granted = grant_r;
  assign self_alert_active = alert_r;
  assign upstream_alert_n = alert_n_r;

  sequence s_trig0;
    reg_wr[0] && reg_addr[0] == asrt_pkg::ARBITER_STATUS_OFS && reg_wdata[0][5];
  endsequence
  sequence s_alert0_low;
    alert_r[0] ##1 (upstream_alert_n[0] == $past(self_alert_mask[0]));
  endsequence

  a_trig_sets_alert: assert property (@(posedge clk) disable iff (sys_rst)
    s_trig0 |=> alert_r[0]) else $error("trigger did not raise alert");
  a_trig_own_only: assert property (@(posedge clk) disable iff (sys_rst)
    s_trig0 and (!alert_r[1] && !(reg_wr[1] && reg_wdata[1][5])) |=> !alert_r[1])
    else $error("trigger leaked to other master");
  a_zero_no_effect: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr[0] && reg_addr[0] == asrt_pkg::ARBITER_STATUS_OFS && !reg_wdata[0][5] && !alert_r[0]
    |=> !alert_r[0] ##1 !rdata_r[0][5]) else $error("zero write changed alert");
  a_alert_holds: assert property (@(posedge clk) disable iff (sys_rst)
    alert_r[0] && !self_alert_flag_clr[0] |=> alert_r[0]) else $error("alert dropped early");
  a_alert_pin: assert property (@(posedge clk) disable iff (sys_rst)
    alert_r[0] |-> s_alert0_low) else $error("alert pin wrong");
  a_inbox_view: assert property (@(posedge clk) disable iff (sys_rst)
    reg_addr[1] == asrt_pkg::ARBITER_STATUS_OFS |=> rdata_r[1][4] == $past(full_r[1]))
    else $error("inbox bit wrong");
  a_outbox_view: assert property (@(posedge clk) disable iff (sys_rst)
    mail_written[0] ##1 reg_addr[0] == asrt_pkg::ARBITER_STATUS_OFS && !mail_taken[1]
    |=> !rdata_r[0][3]) else $error("outbox bit not cleared");
  a_stuck_time: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(stuck_r) |-> $past(hung_r) == asrt_pkg::HUNG_CNT_W'(HUNG_CYC - 1))
    else $error("stuck raised at wrong time");
  a_peer_view: assert property (@(posedge clk) disable iff (sys_rst)
    reg_addr[0] == asrt_pkg::ARBITER_STATUS_OFS |=> rdata_r[0][0] == $past(grant_r[1]))
    else $error("peer lock bit wrong");
  a_reserve_hold: assert property (@(posedge clk) disable iff (sys_rst)
    grant_r[0] && ownership_request[0] && (remain_r > 8'h01 || !timed_r) |=> grant_r[0])
    else $error("reserved owner interrupted");
  a_period_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    grant_r != 2'b00 && grant_nxt == grant_r |=> $stable(timed_r))
    else $error("period altered during grant");
  a_release: assert property (@(posedge clk) disable iff (sys_rst)
    grant_r[1] && !ownership_request[1] |=> !grant_r[1]) else $error("grant not released");
  a_one_owner: assert property (@(posedge clk) disable iff (sys_rst)
    grant_r != 2'b11) else $error("both masters granted");
endmodule // asrt_arbiter
`default_nettype wire

// ===== tb/asrt_side_model.sv
/*
  Model of the far side: the two upstream masters' lock requests and
  the pulled-up downstream lines. Assumes the bench steers it on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module asrt_side_model (
  // Bench commands
  input wire logic [1:0] want,
  input wire logic hold_sda,
  input wire logic hold_scl,
  input wire logic run_scl,
  // Towards the arbiter
  output logic [1:0] ownership_request,
  output logic ds_sda,
  output logic ds_scl
);
  assign ownership_request = want;
  logic scl_clk;

  // Link clock, 200 ns period
  initial
  begin
    scl_clk = 1'b1;
    forever #100 scl_clk = ~scl_clk;
  end

  // Pull-ups: a released line goes high; SCL stands still outside frames
  assign ds_sda = ~hold_sda;
  assign ds_scl = hold_scl ? 1'b0 : (run_scl ? scl_clk : 1'b1);
endmodule // asrt_side_model
`default_nettype wire

// ===== tb/asrt_arbiter_bench.sv
/*
  Self-checking bench for the arbiter status and reserve-time block.
  Assumes shortened tick and hung counts and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module asrt_arbiter_bench;
  localparam int TICK = 10;
  localparam int HUNG = 50;
  logic clk, sys_rst, init_failed, hold_sda, ds_sda, ds_scl;
  logic hold_scl, run_scl;
  logic [1:0] reg_wr, mail_written, mail_taken, self_alert_flag_clr, self_alert_mask;
  logic [1:0] want, ownership_request, ownership_granted, self_alert_active, upstream_alert_n;
  logic [1:0][7:0] reg_addr, reg_wdata, reg_rdata;
  int bad_count = 0;
  int tests_run = 0;

  asrt_arbiter #(.TICK_CYC(TICK), .HUNG_CYC(HUNG)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mail_written(mail_written),
    .mail_taken(mail_taken), .self_alert_flag_clr(self_alert_flag_clr),
    .self_alert_mask(self_alert_mask), .ownership_request(ownership_request),
    .init_failed(init_failed), .ownership_granted(ownership_granted),
    .self_alert_active(self_alert_active), .ds_sda_in(ds_sda), .ds_scl_in(ds_scl),
    .upstream_alert_n(upstream_alert_n));
  asrt_side_model side_u (.want(want), .hold_sda(hold_sda), .hold_scl(hold_scl), .run_scl(run_scl),
    .ownership_request(ownership_request), .ds_sda(ds_sda), .ds_scl(ds_scl));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input int m, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr[m] <= 1'b1;
    reg_addr[m] <= a;
    reg_wdata[m] <= d;
    @(posedge clk);
    reg_wr[m] <= 1'b0;
  endtask

  // Only the bits under k are compared
  task rd(input int m, input logic [7:0] a, input logic [7:0] e, input logic [7:0] k);
    @(posedge clk);
    reg_addr[m] <= a;
    repeat (2) @(posedge clk);
    #1 cmp(reg_rdata[m] & k, e);
  endtask

  task pins(input logic [7:0] e_active, input logic [7:0] e_alert_n);
    repeat (3) @(posedge clk);
    #1 cmp({6'h00, self_alert_active}, e_active);
    cmp({6'h00, upstream_alert_n}, e_alert_n);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    sys_rst = 1'b1;
    {init_failed, hold_sda, hold_scl, run_scl, reg_wr, mail_written, mail_taken} = '0;
    {self_alert_flag_clr, self_alert_mask, want, reg_addr, reg_wdata} = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(0, 8'h02, 8'h00, 8'hF7);
    rd(1, 8'h03, 8'h00, 8'hFF);
    rd(0, 8'h05, 8'h00, 8'hFF);
    wr(0, 8'h02, 8'h00);
    pins(8'h00, 8'h03);
    wr(0, 8'h02, 8'h20);
    pins(8'h01, 8'h02);
    self_alert_mask <= 2'b01;
    pins(8'h01, 8'h03);
    self_alert_mask <= 2'b00;
    self_alert_flag_clr <= 2'b01;
    @(posedge clk);
    self_alert_flag_clr <= 2'b00;
    pins(8'h00, 8'h03);
    rd(1, 8'h02, 8'h08, 8'h08);
    mail_written <= 2'b10;
    @(posedge clk);
    mail_written <= 2'b00;
    rd(0, 8'h02, 8'h18, 8'hFF);
    rd(1, 8'h02, 8'h00, 8'hFF);
    mail_taken <= 2'b01;
    @(posedge clk);
    mail_taken <= 2'b00;
    rd(1, 8'h02, 8'h08, 8'hFF);
    rd(0, 8'h02, 8'h08, 8'hFF);
    rd(0, 8'h02, 8'h08, 8'h08);
    mail_written <= 2'b01;
    @(posedge clk);
    mail_written <= 2'b00;
    rd(0, 8'h02, 8'h00, 8'h08);
    rd(1, 8'h02, 8'h10, 8'h10);
    mail_taken <= 2'b10;
    @(posedge clk);
    mail_taken <= 2'b00;
    wr(0, 8'h03, 8'h02);
    rd(0, 8'h03, 8'h02, 8'hFF);
    want <= 2'b01;
    repeat (3) @(posedge clk);
    #1 cmp({6'h00, ownership_granted}, 8'h01);
    rd(1, 8'h02, 8'h01, 8'h01);
    rd(0, 8'h02, 8'h00, 8'h01);
    want <= 2'b11;
    wr(0, 8'h03, 8'hFF);
    #1 cmp({6'h00, ownership_granted}, 8'h01);
    repeat (15) @(posedge clk);
    #1 cmp({6'h00, ownership_granted}, 8'h02);
    want <= 2'b00;
    repeat (2) @(posedge clk);
    #1 cmp({6'h00, ownership_granted}, 8'h00);
    want <= 2'b10;
    repeat (2) @(posedge clk);
    want <= 2'b11;
    repeat (60) @(posedge clk);
    #1 cmp({6'h00, ownership_granted}, 8'h02);
    want <= 2'b01;
    repeat (3) @(posedge clk);
    #1 cmp({6'h00, ownership_granted}, 8'h01);
    want <= 2'b00;
    hold_sda <= 1'b1;
    run_scl <= 1'b1;
    repeat (HUNG + 10) @(posedge clk);
    rd(0, 8'h02, 8'h00, 8'h04);
    run_scl <= 1'b0;
    repeat (HUNG - 10) @(posedge clk);
    rd(1, 8'h02, 8'h00, 8'h04);
    repeat (10) @(posedge clk);
    rd(0, 8'h02, 8'h04, 8'h04);
    hold_sda <= 1'b0;
    repeat (3) @(posedge clk);
    rd(0, 8'h02, 8'h00, 8'h04);
    hold_scl <= 1'b1;
    repeat (HUNG + 5) @(posedge clk);
    rd(1, 8'h02, 8'h04, 8'h04);
    hold_scl <= 1'b0;
    repeat (3) @(posedge clk);
    rd(1, 8'h02, 8'h00, 8'h04);
    init_failed <= 1'b1;
    rd(1, 8'h02, 8'h02, 8'h02);
    init_failed <= 1'b0;
    rd(1, 8'h02, 8'h00, 8'h02);
    wr(1, 8'h02, 8'h20);
    pins(8'h02, 8'h01);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1 cmp({6'h00, self_alert_active}, 8'h00);
    cmp({6'h00, upstream_alert_n}, 8'h03);
    cmp({6'h00, ownership_granted}, 8'h00);
    rd(1, 8'h02, 8'h08, 8'hFF);
    end_sim();
  end
endmodule // asrt_arbiter_bench
`default_nettype wire
